// >>> logic/sysclk_defines.svh
// Register map, field positions and reset values of the system clock divider
//
// Contract
// - System clock is the oscillator clock divided by the selected ratio.
// - A ratio written at run time takes effect without reset or mode change.
// - The divided clock can be driven out on the clock-output pin.
// - Divide control is one 8-bit read/write register at low address ff5d.
// - Reset and hardware standby load fc; software standby keeps the value.
// - Bits 7 to 2 are read-only, read as ones, writes ignored.
// - Field 00 divides by 1, 01 by 2, 10 by 4, 11 by 8.
// - All on-chip modules are clocked from the divided system clock.
// - Software standby wake-up wait is counted in divided clock cycles.
`ifndef SYSCLK_DEFINES_SVH
`define SYSCLK_DEFINES_SVH

`define SCD_ADDR_W       16
`define SCD_DATA_W       8
`define SCD_CTRL_ADDR    16'hff5d
`define SCD_CTRL_RESET   8'hfc
`define SCD_RATIO_LSB    0
`define SCD_RATIO_MSB    1
`define SCD_RSVD_ONES    6'h3f
`define SCD_READ_IDLE    8'h00
`define SCD_DIV_W        3
`define SCD_WAKE_W       16
`define SCD_WAKE_CYCLES  16'h2000

`endif

// >>> logic/sysclk_pkg.sv
// Types shared by the system clock divider files
package sysclk_pkg;

  typedef enum logic [1:0] {
    ratio_full = 2'b00,
    ratio_div2 = 2'b01,
    ratio_div4 = 2'b10,
    ratio_div8 = 2'b11
  } ratio_e;

  typedef enum logic {
    wake_idle = 1'b0,
    wake_wait = 1'b1
  } wake_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

endpackage

// >>> logic/wrap_counter.sv
// Enabled counter that wraps at a programmable limit
`timescale 1ns/1ps
module wrap_counter #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Control
  input  wire logic             clear,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] limit,
  // Status
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);

  logic [WIDTH-1:0] next_count;

  assign wrap = enable && !clear && (count == limit);

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (wrap) begin
      next_count = '0;
    end else if (enable) begin
      next_count = count + WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule // wrap_counter

// >>> logic/system_clock_divider.sv
// System clock divider with its control register and wake-up wait counter
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "sysclk_defines.svh"
module system_clock_divider #(
  parameter logic [`SCD_WAKE_W-1:0] WAKE_CYCLES = `SCD_WAKE_CYCLES
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  // Register port
  input  sysclk_pkg::reg_req_s         reg_req,
  output logic [`SCD_DATA_W-1:0]       rdata,
  // Power-down state
  input  wire logic                    hw_standby,
  input  wire logic                    sw_standby,
  // Wake-up wait
  input  wire logic                    wake_start,
  output logic                         wake_busy,
  output logic                         wake_done,
  // Divided clock
  output logic                         sys_tick,
  output logic                         clk_out,
  output logic                         clk_out_en
);

  // Ratio field of the reset value; a literal cannot be part-selected
  localparam logic [`SCD_DATA_W-1:0] CTRL_RESET  = `SCD_CTRL_RESET;
  localparam sysclk_pkg::ratio_e     RATIO_RESET = sysclk_pkg::ratio_e'(
    CTRL_RESET[`SCD_RATIO_MSB:`SCD_RATIO_LSB]);

  // Control register and read path
  sysclk_pkg::ratio_e              ratio_sel;
  sysclk_pkg::ratio_e              next_ratio_sel;
  logic [`SCD_DATA_W-1:0]          next_rdata;
  logic                            hit;

  assign hit = (reg_req.addr == `SCD_CTRL_ADDR);

  always_comb begin
    next_ratio_sel = ratio_sel;
    next_rdata     = `SCD_READ_IDLE;
    if (hw_standby) begin
      next_ratio_sel = RATIO_RESET;
    end else if (reg_req.wr && hit) begin
      // Upper bits are not stored, so writes to them vanish
      next_ratio_sel = sysclk_pkg::ratio_e'(
        reg_req.wdata[`SCD_RATIO_MSB:`SCD_RATIO_LSB]);
    end
    if (reg_req.rd && hit) begin
      next_rdata = {`SCD_RSVD_ONES, ratio_sel};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ratio_sel <= RATIO_RESET;
      rdata     <= `SCD_READ_IDLE;
    end else begin
      ratio_sel <= next_ratio_sel;
      rdata     <= next_rdata;
    end
  end

  // Divider
  sysclk_pkg::ratio_e              ratio_live;
  sysclk_pkg::ratio_e              next_ratio_live;
  logic [`SCD_DIV_W-1:0]           div_limit;
  logic [`SCD_DIV_W-1:0]           div_count;
  logic                            raw_tick;

  function automatic logic [`SCD_DIV_W-1:0] ratio_limit(
    input sysclk_pkg::ratio_e r
  );
    logic [`SCD_DIV_W-1:0] lim;
    lim = 3'h0;
    case (r)
      sysclk_pkg::ratio_full: lim = 3'h0;
      sysclk_pkg::ratio_div2: lim = 3'h1;
      sysclk_pkg::ratio_div4: lim = 3'h3;
      sysclk_pkg::ratio_div8: lim = 3'h7;
      default:                lim = 3'h0;
    endcase
    return lim;
  endfunction

  assign div_limit = ratio_limit(ratio_live);

  wrap_counter #(
    .WIDTH (`SCD_DIV_W)
  ) u_div_counter (
    .clock  (clock),
    .rst_b  (rst_b),
    .clear  (hw_standby),
    .enable (1'b1),
    .limit  (div_limit),
    .count  (div_count),
    .wrap   (raw_tick)
  );

  // Switching mid-period would give a short pulse, so wait for the wrap
  always_comb begin
    next_ratio_live = ratio_live;
    if (hw_standby) begin
      next_ratio_live = RATIO_RESET;
    end else if (raw_tick) begin
      next_ratio_live = ratio_sel;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ratio_live <= RATIO_RESET;
    end else begin
      ratio_live <= next_ratio_live;
    end
  end

  // Module enable halts in either standby; the divider keeps running in software standby but is cleared in hardware standby
  assign sys_tick = raw_tick && !sw_standby && !hw_standby;

  // Clock-output pin
  logic                            next_clk_out;
  logic                            next_clk_out_en;

  always_comb begin
    next_clk_out    = raw_tick || sw_standby;
    next_clk_out_en = !hw_standby;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      clk_out    <= 1'b0;
      clk_out_en <= 1'b0;
    end else begin
      clk_out    <= next_clk_out;
      clk_out_en <= next_clk_out_en;
    end
  end

  // Wake-up wait, counted in divided periods
  sysclk_pkg::wake_state_e         wake_state;
  sysclk_pkg::wake_state_e         next_wake_state;
  logic                            next_wake_done;
  logic                            wake_wrap;
  logic [`SCD_WAKE_W-1:0]          wake_count;
  logic [`SCD_WAKE_W-1:0]          wake_limit;

  assign wake_limit = WAKE_CYCLES - `SCD_WAKE_W'(1);
  assign wake_busy  = (wake_state == sysclk_pkg::wake_wait);

  wrap_counter #(
    .WIDTH (`SCD_WAKE_W)
  ) u_wake_counter (
    .clock  (clock),
    .rst_b  (rst_b),
    .clear  (!wake_busy || hw_standby),
    .enable (raw_tick),
    .limit  (wake_limit),
    .count  (wake_count),
    .wrap   (wake_wrap)
  );

  always_comb begin
    next_wake_state = wake_state;
    next_wake_done  = 1'b0;
    case (wake_state)
      sysclk_pkg::wake_idle: begin
        if (wake_start && !hw_standby) begin
          next_wake_state = sysclk_pkg::wake_wait;
        end
      end
      sysclk_pkg::wake_wait: begin
        if (hw_standby) begin
          next_wake_state = sysclk_pkg::wake_idle;
        end else if (wake_wrap) begin
          next_wake_state = sysclk_pkg::wake_idle;
          next_wake_done  = 1'b1;
        end
      end
      default: next_wake_state = sysclk_pkg::wake_idle;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wake_state <= sysclk_pkg::wake_idle;
      wake_done  <= 1'b0;
    end else begin
      wake_state <= next_wake_state;
      wake_done  <= next_wake_done;
    end
  end

  // Checks
  a_read_reserved_ones: assert property (
    @(posedge clock) disable iff (!rst_b)
    reg_req.rd && hit |=> rdata[7:2] == `SCD_RSVD_ONES)
    else $error("reserved bits did not read as ones");

  a_read_ratio_value: assert property (
    @(posedge clock) disable iff (!rst_b)
    reg_req.rd && hit |=> rdata[1:0] == $past(ratio_sel))
    else $error("read data does not match the ratio field");

  a_unmapped_reads_zero: assert property (
    @(posedge clock) disable iff (!rst_b)
    !(reg_req.rd && hit) |=> rdata == `SCD_READ_IDLE)
    else $error("read data not idle outside a register read");

  a_write_takes_ratio: assert property (
    @(posedge clock) disable iff (!rst_b)
    reg_req.wr && hit && !hw_standby
      |=> ratio_sel == $past(reg_req.wdata[1:0]))
    else $error("written ratio not stored");

  a_hw_standby_init: assert property (
    @(posedge clock) disable iff (!rst_b)
    hw_standby |=> ratio_sel == sysclk_pkg::ratio_full
      && ratio_live == sysclk_pkg::ratio_full)
    else $error("hardware standby did not reinitialise the ratio");

  a_sw_standby_keeps: assert property (
    @(posedge clock) disable iff (!rst_b)
    sw_standby && !hw_standby && !reg_req.wr |=> $stable(ratio_sel))
    else $error("ratio changed during software standby");

  a_div8_spacing: assert property (
    @(posedge clock) disable iff (!rst_b || hw_standby)
    raw_tick && ratio_sel == sysclk_pkg::ratio_div8
      |=> !raw_tick [*7] ##1 raw_tick)
    else $error("divide by eight period wrong");

  a_div2_spacing: assert property (
    @(posedge clock) disable iff (!rst_b || hw_standby)
    raw_tick && ratio_sel == sysclk_pkg::ratio_div2
      |=> !raw_tick ##1 raw_tick)
    else $error("divide by two period wrong");

  a_div4_spacing: assert property (
    @(posedge clock) disable iff (!rst_b || hw_standby)
    raw_tick && ratio_sel == sysclk_pkg::ratio_div4
      |=> !raw_tick [*3] ##1 raw_tick)
    else $error("divide by four period wrong");

  a_full_every_cycle: assert property (
    @(posedge clock) disable iff (!rst_b || hw_standby)
    raw_tick && ratio_sel == sysclk_pkg::ratio_full |=> raw_tick)
    else $error("divide by one does not tick every cycle");

  a_ratio_on_boundary: assert property (
    @(posedge clock) disable iff (!rst_b)
    !$stable(ratio_live)
      |-> $past(raw_tick) || $past(hw_standby) || !$past(rst_b))
    else $error("ratio switched inside a divided period");

  a_pin_follows_tick: assert property (
    @(posedge clock) disable iff (!rst_b)
    raw_tick && !hw_standby |=> clk_out && clk_out_en)
    else $error("clock pin does not follow the divided clock");

  a_module_tick_gated: assert property (
    @(posedge clock) disable iff (!rst_b)
    sys_tick |-> div_count == div_limit && !sw_standby && !hw_standby)
    else $error("module enable outside a divided tick");

  a_wake_on_tick: assert property (
    @(posedge clock) disable iff (!rst_b)
    wake_done |-> $past(raw_tick) && $past(wake_busy) && !wake_busy)
    else $error("wake wait ended off a divided tick");

  a_wake_starts: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(wake_busy) |-> $past(wake_start))
    else $error("wake wait started without a request");

endmodule // system_clock_divider

// >>> dv/test_system_clock_divider.sv
// Self-checking testbench of the system clock divider
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
  end \
end

module test_system_clock_divider;
  // Short wake wait keeps the run brief
  localparam int WAKE = 4;

  logic                 clock;
  logic                 rst_b;
  sysclk_pkg::reg_req_s req;
  logic [7:0]           rdata;
  logic                 hw_standby;
  logic                 sw_standby;
  logic                 wake_start;
  logic                 wake_busy;
  logic                 wake_done;
  logic                 sys_tick;
  logic                 clk_out;
  logic                 clk_out_en;
  int                   n_errors;
  int                   tests_run;
  int                   n;
  int                   k;

  system_clock_divider #(
    .WAKE_CYCLES (16'(WAKE))
  ) i_dut (
    .clock      (clock),
    .rst_b      (rst_b),
    .reg_req    (req),
    .rdata      (rdata),
    .hw_standby (hw_standby),
    .sw_standby (sw_standby),
    .wake_start (wake_start),
    .wake_busy  (wake_busy),
    .wake_done  (wake_done),
    .sys_tick   (sys_tick),
    .clk_out    (clk_out),
    .clk_out_en (clk_out_en)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  // Read data stand one cycle only, then the port idles at zero
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    `CHK("rdata", exp, rdata)
    @(negedge clock);
    `CHK("rdata idle", 8'h00, rdata)
  endtask

  task automatic wait_tick;
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clock);
      if (sys_tick === 1'b1) break;
    end
  endtask

  // Counts ticks; the pin must echo the tick of the cycle before
  task automatic count_ticks(input int cycles, output int cnt);
    logic p;
    cnt = 0;
    @(negedge clock);
    p = sys_tick;
    repeat (cycles) begin
      @(negedge clock);
      `CHK("clk_out", p, clk_out)
      if (sys_tick === 1'b1) cnt++;
      p = sys_tick;
    end
  endtask

  initial begin
    n_errors   = 0;
    tests_run  = 0;
    rst_b      = 1'b0;
    hw_standby = 1'b0;
    sw_standby = 1'b0;
    wake_start = 1'b0;
    req        = '0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rd_reg(16'hff5d, 8'hfc);
    rd_reg(16'hff5c, 8'h00);
    wr_reg(16'hff5e, 8'h03);
    rd_reg(16'hff5d, 8'hfc);
    for (int r = 0; r < 4; r++) begin
      // Eight times slower still leaves a safe rate at this clock
      wr_reg(16'hff5d, {6'h00, r[1:0]});
      rd_reg(16'hff5d, {6'h3f, r[1:0]});
      repeat (10) @(posedge clock);
      count_ticks(32, n);
      `CHK("ticks in 32", 32 >> r, n)
    end
    `CHK("pin enable", 1'b1, clk_out_en)
    // Switch from eight to one mid-period: old period must finish
    wr_reg(16'hff5d, 8'h03);
    wait_tick;
    wait_tick;
    @(posedge clock);
    req.wdata <= 8'h00;
    req.wr    <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
    n = 2;
    for (k = 0; k < 20; k++) begin
      @(negedge clock);
      if (sys_tick === 1'b1) break;
      n++;
    end
    `CHK("switch period", 8, n)
    @(negedge clock);
    `CHK("full rate after switch", 1'b1, sys_tick)
    // Wake wait counts divided periods, so run it at divide by two
    wr_reg(16'hff5d, 8'h01);
    @(posedge clock);
    wake_start <= 1'b1;
    @(posedge clock);
    wake_start <= 1'b0;
    n = 0;
    k = 0;
    for (int i = 0; i < 100; i++) begin
      @(negedge clock);
      if (wake_busy === 1'b1 && sys_tick === 1'b1) n++;
      if (wake_done === 1'b1) begin
        k = 1;
        break;
      end
    end
    `CHK("wake ticks", WAKE, n)
    `CHK("wake done", 1, k)
    @(posedge clock);
    sw_standby <= 1'b1;
    repeat (3) @(negedge clock);
    `CHK("pin in sw standby", 1'b1, clk_out)
    `CHK("tick in sw standby", 1'b0, sys_tick)
    @(posedge clock);
    sw_standby <= 1'b0;
    rd_reg(16'hff5d, 8'hfd);
    @(posedge clock);
    hw_standby <= 1'b1;
    // Standby wins over a write in the same cycle
    wr_reg(16'hff5d, 8'h02);
    @(negedge clock);
    `CHK("enable in hw standby", 1'b0, clk_out_en)
    @(posedge clock);
    hw_standby <= 1'b0;
    rd_reg(16'hff5d, 8'hfc);
    // Mid-run reset reloads the register
    wr_reg(16'hff5d, 8'h03);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(negedge clock);
    `CHK("pin enable in reset", 1'b0, clk_out_en)
    @(posedge clock);
    rst_b <= 1'b1;
    rd_reg(16'hff5d, 8'hfc);
    end_sim;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    end_sim;
  end
endmodule // test_system_clock_divider
